// ### design/fpc_regs.svh
// Register map, field positions and key values of the flash program control
// Assumes a 32-bit register port with word-aligned byte offsets
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH

// ----------------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------------
`define FPC_OFF_CTRL    8'h00
`define FPC_OFF_UNLOCK  8'h04
`define FPC_OFF_TADDR   8'h08
`define FPC_OFF_ISTAT   8'h0C
`define FPC_OFF_IMASK   8'h10

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define FPC_BIT_START   15
`define FPC_BIT_GATE    14
`define FPC_BIT_FAIL    13
`define FPC_BIT_LVERR   12
`define FPC_BIT_LVACT   11
`define FPC_OP_HI       3
`define FPC_OP_LO       0

// ----------------------------------------------------------------------------
// Operation codes, unlock keys, interrupt bits
// ----------------------------------------------------------------------------
`define FPC_OP_CLEAR    4'h0
`define FPC_OP_WORD     4'h1
`define FPC_OP_ROW      4'h3
`define FPC_OP_PAGE     4'h4
`define FPC_OP_ARRAY    4'h5
`define FPC_KEY1        32'hAA99_6655
`define FPC_KEY2        32'h5566_99AA
`define FPC_IRQ_DONE    0
`define FPC_IRQ_FAIL    1
`define FPC_IRQ_LVERR   2
`define FPC_IRQ_W       3

`endif

// ### design/fpc_pkg.sv
// Types shared by the flash program control
// Assumes fpc_regs.svh for the numeric constants
package fpc_pkg;
  typedef enum logic {FPC_IDLE, FPC_RUN} fpc_state_t;
  typedef logic [3:0]  fpc_op_t;
  typedef logic [7:0]  fpc_addr_t;
  typedef logic [31:0] fpc_word_t;
endpackage

// ### design/fpc_ctrl.sv
// Flash program control: register port, unlock, sequencing, flags, interrupt
// Assumes an on-chip flash array on CLK_SYS and an asynchronous detector level
`timescale 1ns/1ps
`default_nettype none
`include "fpc_regs.svh"

module fpc_ctrl #(
  parameter int TADDR_W = 32
) (
  // Clock and resets
  input  wire logic              CLK_SYS,
  input  wire logic              RST,
  input  wire logic              POR_RST,
  // Register port
  input  wire fpc_pkg::fpc_addr_t ADDR,
  input  wire fpc_pkg::fpc_word_t WR_DATA,
  input  wire logic              WR_EN,
  input  wire logic              RD_EN,
  output logic [31:0]            RD_DATA,
  // Flash array
  output logic                   FLASH_REQ,
  output fpc_pkg::fpc_op_t       FLASH_OP,
  output logic [TADDR_W-1:0]     FLASH_ADDR,
  input  wire logic              FLASH_DONE,
  input  wire logic              FLASH_FAIL,
  input  wire logic              WP_TARGET,
  input  wire logic              WP_ANY,
  // Low-voltage detector
  output logic                   LVD_EN,
  input  wire logic              LVD_LOW,
  // Interrupt
  output logic                   IRQ
);
  import fpc_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  fpc_state_t         st_ff;
  logic               start_ff;
  logic               gate_ff;
  logic               fail_ff;
  logic               lverr_ff;
  logic               lvact_ff;
  fpc_op_t            op_ff;
  logic [TADDR_W-1:0] taddr_ff;
  logic               key1_ff;
  logic               unlocked_ff;
  logic               lvd_s1_ff;
  logic               lvd_s2_ff;
  logic [`FPC_IRQ_W-1:0] istat_ff;
  logic [`FPC_IRQ_W-1:0] imask_ff;
  logic               req_ff;
  logic [31:0]        rd_ff;
  logic               irq_ff;

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  function automatic logic op_real(input fpc_op_t op);
    op_real = (op == `FPC_OP_WORD) || (op == `FPC_OP_ROW) ||
              (op == `FPC_OP_PAGE) || (op == `FPC_OP_ARRAY);
  endfunction

  function automatic logic hit(input fpc_addr_t a, input fpc_addr_t off);
    hit = (a == off);
  endfunction

  logic wr_ctrl;
  logic start_req;
  logic protect;
  logic launch;
  logic op_done;
  logic low_now;
  logic run_fail;
  logic [`FPC_IRQ_W-1:0] ev;

  assign wr_ctrl   = WR_EN && hit(ADDR, `FPC_OFF_CTRL);
  assign start_req = wr_ctrl && WR_DATA[`FPC_BIT_START] && gate_ff &&
                     unlocked_ff && !start_ff;
  assign protect   = (op_ff == `FPC_OP_ARRAY) ? WP_ANY : WP_TARGET;
  assign launch    = start_req && op_real(op_ff) && !protect;
  assign op_done   = start_ff &&
                     ((st_ff == FPC_IDLE) || FLASH_DONE);
  assign low_now   = gate_ff && lvd_s2_ff;
  assign run_fail  = (st_ff == FPC_RUN) && FLASH_DONE &&
                     (FLASH_FAIL || low_now);
  assign ev[`FPC_IRQ_DONE]  = op_done;
  assign ev[`FPC_IRQ_FAIL]  = run_fail ||
                              (start_req && op_real(op_ff) && protect);
  assign ev[`FPC_IRQ_LVERR] = low_now && !lverr_ff;

  // --------------------------------------------------------------------------
  // Detector level synchroniser
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (POR_RST) begin
      lvd_s1_ff <= 1'b0;
      lvd_s2_ff <= 1'b0;
    end else begin
      lvd_s1_ff <= LVD_LOW;
      lvd_s2_ff <= lvd_s1_ff;
    end
  end

  // --------------------------------------------------------------------------
  // Unlock sequence: next write after the two keys must be the start
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (POR_RST || RST) begin
      key1_ff     <= 1'b0;
      unlocked_ff <= 1'b0;
    end else if (WR_EN) begin
      key1_ff     <= hit(ADDR, `FPC_OFF_UNLOCK) && (WR_DATA == `FPC_KEY1);
      unlocked_ff <= hit(ADDR, `FPC_OFF_UNLOCK) && key1_ff &&
                     (WR_DATA == `FPC_KEY2);
    end
  end

  // --------------------------------------------------------------------------
  // Write gate, operation select, target address
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (POR_RST || RST) begin
      gate_ff <= 1'b0;
    end else if (wr_ctrl) begin
      gate_ff <= WR_DATA[`FPC_BIT_GATE];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (POR_RST) begin
      op_ff    <= `FPC_OP_CLEAR;
      taddr_ff <= '0;
    end else begin
      if (wr_ctrl && !gate_ff) begin
        op_ff <= WR_DATA[`FPC_OP_HI:`FPC_OP_LO];
      end
      if (WR_EN && hit(ADDR, `FPC_OFF_TADDR) && !start_ff) begin
        taddr_ff <= WR_DATA[TADDR_W-1:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (POR_RST) begin
      st_ff    <= FPC_IDLE;
      start_ff <= 1'b0;
      req_ff   <= 1'b0;
    end else begin
      req_ff <= launch;
      if (start_req) begin
        start_ff <= 1'b1;
      end else if (op_done) begin
        start_ff <= 1'b0;
      end
      unique case (st_ff)
        FPC_IDLE: begin
          if (launch) begin
            st_ff <= FPC_RUN;
          end
        end
        FPC_RUN: begin
          if (FLASH_DONE) begin
            st_ff <= FPC_IDLE;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Status flags
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (POR_RST) begin
      fail_ff <= 1'b0;
    end else if (start_req && op_ff == `FPC_OP_CLEAR) begin
      fail_ff <= 1'b0;
    end else if (start_req && op_real(op_ff)) begin
      fail_ff <= protect;
    end else if (st_ff == FPC_RUN && FLASH_DONE) begin
      fail_ff <= run_fail;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (POR_RST) begin
      lverr_ff <= 1'b0;
      lvact_ff <= 1'b0;
    end else begin
      if (low_now) begin
        lverr_ff <= 1'b1;
      end else if (start_req && op_ff == `FPC_OP_CLEAR) begin
        lverr_ff <= 1'b0;
      end
      lvact_ff <= low_now &&
                  !(start_req && op_ff == `FPC_OP_CLEAR);
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status and mask
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (POR_RST || RST) begin
      istat_ff <= '0;
      imask_ff <= '0;
    end else begin
      if (WR_EN && hit(ADDR, `FPC_OFF_ISTAT)) begin
        istat_ff <= (istat_ff & ~WR_DATA[`FPC_IRQ_W-1:0]) | ev;
      end else begin
        istat_ff <= istat_ff | ev;
      end
      if (WR_EN && hit(ADDR, `FPC_OFF_IMASK)) begin
        imask_ff <= WR_DATA[`FPC_IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (POR_RST || RST) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(istat_ff & imask_ff);
    end
  end

  // --------------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(ADDR, `FPC_OFF_CTRL)) begin
      rd_mux[`FPC_BIT_START]          = start_ff;
      rd_mux[`FPC_BIT_GATE]           = gate_ff;
      rd_mux[`FPC_BIT_FAIL]           = fail_ff;
      rd_mux[`FPC_BIT_LVERR]          = lverr_ff;
      rd_mux[`FPC_BIT_LVACT]          = lvact_ff;
      rd_mux[`FPC_OP_HI:`FPC_OP_LO]   = op_ff;
    end else if (hit(ADDR, `FPC_OFF_TADDR)) begin
      rd_mux[TADDR_W-1:0] = taddr_ff;
    end else if (hit(ADDR, `FPC_OFF_ISTAT)) begin
      rd_mux[`FPC_IRQ_W-1:0] = istat_ff;
    end else if (hit(ADDR, `FPC_OFF_IMASK)) begin
      rd_mux[`FPC_IRQ_W-1:0] = imask_ff;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (POR_RST || RST) begin
      rd_ff <= 32'h0000_0000;
    end else if (RD_EN) begin
      rd_ff <= rd_mux;
    end else begin
      rd_ff <= 32'h0000_0000;
    end
  end

  assign RD_DATA    = rd_ff;
  assign FLASH_REQ  = req_ff;
  assign FLASH_OP   = op_ff;
  assign FLASH_ADDR = taddr_ff;
  assign LVD_EN     = gate_ff;
  assign IRQ        = irq_ff;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (POR_RST);

  start_needs_key_a: assert property (
    $rose(start_ff) |-> $past(gate_ff) && $past(unlocked_ff))
    else $error("start accepted without gate and unlock");

  start_clears_a: assert property (
    start_ff && st_ff == FPC_IDLE && !req_ff |=> !start_ff)
    else $error("start bit not cleared after immediate operation");

  reset_gate_a: assert property (
    RST |=> !gate_ff && !LVD_EN)
    else $error("gate not cleared by reset");

  keep_op_a: assert property (
    RST && !POR_RST |=> $stable(op_ff))
    else $error("operation select changed by reset");

  op_locked_a: assert property (
    gate_ff |=> $stable(op_ff))
    else $error("operation select changed while gate set");

  req_valid_a: assert property (
    FLASH_REQ |-> op_real(FLASH_OP) && st_ff == FPC_RUN)
    else $error("flash request for a non operation");

  protect_fail_a: assert property (
    start_req && op_real(op_ff) && protect |=> !FLASH_REQ && fail_ff)
    else $error("protected target was not refused");

  clear_flags_a: assert property (
    start_req && op_ff == `FPC_OP_CLEAR && !low_now
    |=> !fail_ff && !lverr_ff && !lvact_ff)
    else $error("clear code did not clear flags");

  lvd_off_a: assert property (
    !gate_ff && !lverr_ff |=> !lverr_ff || $past(low_now))
    else $error("error flag set with detector off");

  lvact_track_a: assert property (
    lvact_ff |-> $past(gate_ff) && $past(lvd_s2_ff))
    else $error("low voltage status without active event");

  ctrl_zero_a: assert property (
    RD_EN && hit(ADDR, `FPC_OFF_CTRL) |=> RD_DATA[31:16] == 16'h0000 &&
    RD_DATA[10:4] == 7'h00)
    else $error("reserved control bits read non zero");

  lverr_set_a: assert property (
    gate_ff && lvd_s2_ff |=> lverr_ff)
    else $error("error flag missed a low voltage event");

  fail_done_a: assert property (
    st_ff == FPC_RUN && FLASH_DONE |=> fail_ff == $past(run_fail))
    else $error("fail flag does not follow completion");

  fail_event_a: assert property (
    run_fail && !RST |=> istat_ff[`FPC_IRQ_FAIL])
    else $error("fail event not recorded in status");

  irq_level_a: assert property (
    |(istat_ff & imask_ff) && !RST |=> IRQ)
    else $error("interrupt low with unmasked status set");

  run_cov_c:   cover property (launch ##[1:50] (st_ff == FPC_RUN && FLASH_DONE));
  clear_cov_c: cover property (start_req && op_ff == `FPC_OP_CLEAR);
  prot_cov_c:  cover property (start_req && op_real(op_ff) && protect);
  irq_cov_c:   cover property ($rose(IRQ));
endmodule

`default_nettype wire

// ### sim/fpc_flash_model.sv
// Behavioural flash array answering launch pulses after a set latency
// Assumes one launch at a time on the system clock
`timescale 1ns/1ps
`default_nettype none

module fpc_flash_model (
  // Clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       RST,
  // Launch and answer
  input  wire logic       FLASH_REQ,
  output logic            FLASH_DONE,
  output logic            FLASH_FAIL,
  // Bench control
  input  wire logic [7:0] LAT,
  input  wire logic       FAIL_SET
);
  logic [7:0] cnt_ff;
  logic       busy_ff;
  logic       junk_ff;

  // Fail line is noise outside the done pulse
  assign FLASH_FAIL = FLASH_DONE ? FAIL_SET : junk_ff;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      busy_ff    <= 1'b0;
      cnt_ff     <= 8'h00;
      FLASH_DONE <= 1'b0;
      junk_ff    <= 1'b0;
    end else begin
      junk_ff    <= ~junk_ff;
      FLASH_DONE <= 1'b0;
      if (FLASH_REQ && !busy_ff) begin
        busy_ff <= 1'b1;
        cnt_ff  <= LAT;
      end else if (busy_ff) begin
        if (cnt_ff <= 8'h01) begin
          busy_ff    <= 1'b0;
          FLASH_DONE <= 1'b1;
        end
        cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

// ### sim/flash_program_control_bench.sv
// Self-checking bench for the flash program control
// Assumes fpc_ctrl, fpc_flash_model and fpc_regs.svh are compiled
`timescale 1ns/1ps
`default_nettype none
`include "fpc_regs.svh"

module flash_program_control_bench;
  import fpc_pkg::*;
  logic        clk_sys, rst, por, wr_en, rd_en, wp_tgt, wp_any;
  logic        lvd_low, flt, req, done, fail, lvd_en, irq;
  fpc_addr_t   addr;
  fpc_word_t   wr_data;
  fpc_op_t     fop, req_op;
  logic [31:0] rd_data, taddr, d, faddr, req_addr;
  logic [7:0]  lat;
  logic [6:0]  tbl [12];
  logic [3:0]  r_op;
  logic [2:0]  r_mask;
  logic        r_fail, r_lverr;
  int          err_total, n_tests, req_cnt, seed;
  fpc_op_t     exp_q [$];

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  fpc_ctrl i_fpc_ctrl (.CLK_SYS(clk_sys), .RST(rst), .POR_RST(por),
    .ADDR(addr), .WR_DATA(wr_data), .WR_EN(wr_en), .RD_EN(rd_en),
    .RD_DATA(rd_data), .FLASH_REQ(req), .FLASH_OP(fop),
    .FLASH_ADDR(faddr), .FLASH_DONE(done), .FLASH_FAIL(fail),
    .WP_TARGET(wp_tgt), .WP_ANY(wp_any), .LVD_EN(lvd_en),
    .LVD_LOW(lvd_low), .IRQ(irq));

  fpc_flash_model i_fpc_flash_model (.CLK_SYS(clk_sys), .RST(por),
    .FLASH_REQ(req), .FLASH_DONE(done), .FLASH_FAIL(fail), .LAT(lat),
    .FAIL_SET(flt));

  always @(posedge clk_sys) begin
    if (req === 1'b1) begin
      req_cnt++;
      req_op   = fop;
      req_addr = faddr;
    end
  end

  task automatic results;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    addr    <= a;
    wr_data <= v;
    wr_en   <= 1'b1;
    @(posedge clk_sys);
    wr_en   <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(negedge clk_sys);
    v = rd_data;
  endtask

  task automatic settle;
    repeat (4) @(negedge clk_sys);
  endtask

  function automatic logic [31:0] ctl(input logic g, input logic la);
    return {16'h0000, 1'b0, g, r_fail, r_lverr, la, 7'h00, r_op};
  endfunction

  // One start request, launched only for an unprotected real op: {op, target protected, any protected, array fail}
  task automatic go(input logic [6:0] c);
    logic ok, prot, evf;
    int   n0, i;
    ok   = c[6:3] inside {`FPC_OP_WORD, `FPC_OP_ROW, `FPC_OP_PAGE,
                          `FPC_OP_ARRAY};
    prot = (c[6:3] == `FPC_OP_ARRAY) ? c[1] : c[2];
    evf  = ok & (prot | c[0]);
    @(posedge clk_sys);
    wp_tgt <= c[2];
    wp_any <= c[1];
    flt    <= c[0];
    lat    <= 8'h04 + 8'($unsigned($random(seed)) % 4);
    r_mask = 3'($random(seed));
    wr(`FPC_OFF_IMASK, {29'h0, r_mask});
    wr(`FPC_OFF_CTRL, 32'h0);
    settle();
    chk(0, lvd_en);
    wr(`FPC_OFF_CTRL, {28'h0, c[6:3]});
    wr(`FPC_OFF_CTRL, 32'h4000 + c[6:3]);
    settle();
    chk(1, lvd_en);
    wr(`FPC_OFF_UNLOCK, `FPC_KEY1);
    wr(`FPC_OFF_UNLOCK, `FPC_KEY2);
    n0 = req_cnt;
    if (ok && !prot) exp_q.push_back(c[6:3]);
    wr(`FPC_OFF_CTRL, 32'hC000 + c[6:3]);
    rd(`FPC_OFF_CTRL, d);
    if (ok && !prot) chk(1, d[15]);
    i = 0;
    while (d[15] !== 1'b0 && i < 50) begin
      rd(`FPC_OFF_CTRL, d);
      i++;
    end
    if (d[15] !== 1'b0) begin
      err_total++;
      results();
    end
    r_op = c[6:3];
    if (c[6:3] == `FPC_OP_CLEAR) begin
      r_fail  = 1'b0;
      r_lverr = 1'b0;
    end else if (ok) r_fail = evf;
    chk(ctl(1, 0), d);
    chk(n0 + (ok && !prot), req_cnt);
    if (ok && !prot) chk(exp_q.pop_front(), req_op);
    if (ok && !prot) chk(taddr, req_addr);
    rd(`FPC_OFF_ISTAT, d);
    chk({30'h0, evf, 1'b1}, d);
    chk(|({evf, 1'b1} & r_mask[1:0]), irq);
    wr(`FPC_OFF_ISTAT, 32'h7);
    settle();
    chk(0, irq);
  endtask

  initial begin
    seed = 32'hC16B;
    {err_total, n_tests, req_cnt} = '0;
    {rst, por} = 2'b11;
    {wr_en, rd_en, lvd_low, wp_tgt, wp_any, flt} = '0;
    addr = '0;
    wr_data = '0;
    lat = 8'h04;
    {r_fail, r_lverr, r_op, r_mask} = '0;
    tbl = '{7'h08, 7'h19, 7'h10, 7'h30, 7'h38, 7'h78, 7'h00, 7'h20,
            7'h24, 7'h2C, 7'h0A, 7'h2A};
    repeat (5) @(posedge clk_sys);
    {rst, por} <= 2'b00;
    rd(`FPC_OFF_CTRL, d);
    chk(ctl(0, 0), d);
    taddr = $random(seed);
    wr(`FPC_OFF_TADDR, taddr);
    wr(`FPC_OFF_CTRL, 32'h4001);
    wr(`FPC_OFF_CTRL, 32'hC001);
    rd(`FPC_OFF_CTRL, d);
    chk(32'h4001, d);
    for (int k = 0; k < 12; k++) go(tbl[k]);
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    rd(`FPC_OFF_CTRL, d);
    chk(ctl(0, 0), d);
    wr(`FPC_OFF_CTRL, 32'h0);
    r_op = 4'h0;
    @(posedge clk_sys);
    lvd_low <= 1'b1;
    settle();
    rd(`FPC_OFF_CTRL, d);
    chk(ctl(0, 0), d);
    wr(`FPC_OFF_CTRL, 32'h4003);
    r_op = 4'h3;
    settle();
    r_lverr = 1'b1;
    rd(`FPC_OFF_CTRL, d);
    chk(ctl(1, 1), d);
    @(posedge clk_sys);
    lvd_low <= 1'b0;
    settle();
    rd(`FPC_OFF_CTRL, d);
    chk(ctl(1, 0), d);
    rd(`FPC_OFF_ISTAT, d);
    chk(32'h4, d & 32'h4);
    wr(`FPC_OFF_ISTAT, 32'h7);
    go(7'h00);
    wr(`FPC_OFF_CTRL, 32'hFFFF_07F1);
    rd(`FPC_OFF_CTRL, d);
    chk(ctl(0, 0), d);
    wr(`FPC_OFF_CTRL, 32'hFFFF_07F1);
    r_op = 4'h1;
    rd(`FPC_OFF_CTRL, d);
    chk(ctl(0, 0), d);
    rd(8'h40, d);
    chk(0, d);
    results();
  end

  initial begin
    #200000;
    err_total++;
    results();
  end
endmodule

`default_nettype wire
